// >>> common/transient_map.svh
// Register indices, field positions, reset values and constants of the transient detector.
`ifndef TRANSIENT_MAP_SVH
`define TRANSIENT_MAP_SVH

// Register indices; the byte address of each register is four times its index.
`define TD_IDX_CONFIG 8'h1D
`define TD_IDX_SOURCE 8'h1E
`define TD_IDX_THRESH 8'h1F
`define TD_IDX_COUNT 8'h20
`define TD_IDX_DEBUG 8'h3F

// Reset values.
`define TD_RST_CONFIG 8'h00
`define TD_RST_SOURCE 8'h00
`define TD_RST_THRESH 8'h00
`define TD_RST_COUNT 8'h00

// Field positions of the configuration register.
`define TD_CFG_LATCH_BIT 4
`define TD_CFG_BYPASS_BIT 0

// Field positions of the source register.
`define TD_SRC_ACTIVE_BIT 6

// Field position of the counter mode bit in the threshold register.
`define TD_THS_MODE_BIT 7

// Sample and filter widths.
`define TD_SAMPLE_W 14
`define TD_FILT_W 16
`define TD_HPF_SHIFT 4
`define TD_ACC_W 20

// One threshold step is 63 mg; with 14-bit samples at +/-8 g one step is 64 counts.
`define TD_TH_SHIFT 6

`endif

// >>> common/transient_pkg.sv
// Types shared by the transient detector files.
package transient_pkg;

  typedef logic [2:0][13:0] axes_type;

  typedef struct packed {
    logic [2:0] unused;
    logic latch_en;
    logic [2:0] axis_en;
    logic hpf_bypass;
  } config_type;

  typedef struct packed {
    logic flag;
    logic pol;
  } axis_status_type;

  typedef struct packed {
    logic unused;
    logic any_event_active;
    axis_status_type [2:0] axis;
  } source_type;

  typedef struct packed {
    logic debounce_counter_mode;
    logic [6:0] ac_threshold_value;
  } thresh_type;

  typedef struct packed {
    logic pending;
    logic [7:0] idx;
  } write_phase_type;

endpackage : transient_pkg

// >>> hw/hp_filter.sv
// First-order high-pass filter for one acceleration axis, with bypass.
`include "transient_map.svh"

module hp_filter (
  input wire logic clk,
  input wire logic reset,
  input wire logic bypass,
  input wire logic in_valid,
  input wire logic [13:0] in_data,
  output logic out_valid,
  output logic [15:0] out_data
);

  logic signed [`TD_ACC_W-1:0] acc;
  logic signed [`TD_ACC_W-1:0] next_acc;
  logic [15:0] next_out;
  logic signed [15:0] wide_in;
  logic signed [15:0] avg;
  logic signed [15:0] diff;

  always_comb begin
    wide_in = 16'($signed(in_data));
    avg = 16'(acc >>> `TD_HPF_SHIFT);
    diff = wide_in - avg;
    next_acc = acc;
    next_out = out_data;
    if (in_valid) begin
      if (bypass) begin
        // Preloading the average avoids a step at the output when the filter is re-enabled.
        next_acc = `TD_ACC_W'(wide_in) <<< `TD_HPF_SHIFT;
        next_out = wide_in;
      end else begin
        next_acc = acc + `TD_ACC_W'(diff);
        next_out = diff;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      acc <= '0;
      out_data <= 16'h0000;
      out_valid <= 1'b0;
    end else begin
      acc <= next_acc;
      out_data <= next_out;
      out_valid <= in_valid;
    end
  end

  a_bypass_raw: assert property (@(posedge clk) disable iff (reset)
    in_valid && bypass |=> out_data == 16'($signed($past(in_data))))
    else $error("bypassed filter output differs from raw sample");

endmodule : hp_filter

// >>> hw/axis_compare.sv
// Magnitude and sign compare of one filtered axis against the transient threshold.
`include "transient_map.svh"

module axis_compare (
  input wire logic [15:0] data,
  input wire logic [6:0] threshold,
  output logic above,
  output logic negative
);

  logic [15:0] magnitude;
  logic [15:0] limit;

  always_comb begin
    negative = data[15];
    magnitude = negative ? 16'(-data) : data;
    limit = 16'(threshold) << `TD_TH_SHIFT;
    above = magnitude > limit;
  end

endmodule : axis_compare

// >>> hw/transient_detect.sv
// Transient acceleration event detector with its AHB-Lite register slave.
//
// Our own choice: the AHB-Lite interface to the registers.
`include "transient_map.svh"

module transient_detect (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input wire logic SAMPLE_VALID,
  input wire transient_pkg::axes_type SAMPLE_DATA,
  output logic EVENT_ACTIVE
);

  // Bus state.
  transient_pkg::write_phase_type wphase;
  transient_pkg::write_phase_type next_wphase;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic take;
  logic mapped;
  logic [7:0] idx;
  logic rd_clear;

  // Software registers.
  transient_pkg::config_type cfg;
  transient_pkg::config_type next_cfg;
  transient_pkg::thresh_type ths;
  transient_pkg::thresh_type next_ths;
  logic [7:0] debounce_count_value;
  logic [7:0] next_debounce_count_value;

  // Detector state.
  transient_pkg::source_type src;
  transient_pkg::source_type next_src;
  transient_pkg::source_type live;
  logic [7:0] dbc;
  logic [7:0] next_dbc;
  logic cond;
  logic fire;
  logic tick;

  // Per-axis datapath.
  logic [2:0] fvalid;
  logic [2:0][15:0] fdata;
  logic [2:0] above;
  logic [2:0] negative;

  // Address phase decode; transfers are always accepted without wait states.
  always_comb begin
    take = HSEL && HREADY && HTRANS[1];
    mapped = HADDR[31:10] == 22'h000000;
    idx = HADDR[9:2];
    rd_clear = take && !HWRITE && mapped && idx == `TD_IDX_SOURCE;
  end

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata;
  assign EVENT_ACTIVE = src.any_event_active;

  function automatic logic [31:0] read_mux(input logic hit, input logic [7:0] i,
                                           input logic [31:0] cfg_w, input logic [31:0] src_w,
                                           input logic [31:0] ths_w, input logic [31:0] cnt_w,
                                           input logic [31:0] dbg_w);
    logic [31:0] value;
    value = 32'h00000000;
    if (hit) begin
      unique case (i)
        `TD_IDX_CONFIG: value = cfg_w;
        `TD_IDX_SOURCE: value = src_w;
        `TD_IDX_THRESH: value = ths_w;
        `TD_IDX_COUNT: value = cnt_w;
        `TD_IDX_DEBUG: value = dbg_w;
        default: value = 32'h00000000;
      endcase
    end
    return value;
  endfunction : read_mux

  always_comb begin
    next_wphase.pending = take && HWRITE && mapped;
    next_wphase.idx = idx;
    next_rdata = rdata;
    if (take && !HWRITE) begin
      // Read data are captured at the address phase, so a read right after a write
      // to the same register returns the value from before that write.
      next_rdata = read_mux(mapped, idx, 32'(cfg), 32'(src), 32'(ths),
                            32'(debounce_count_value), 32'(dbc));
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      wphase <= '0;
      rdata <= 32'h00000000;
    end else begin
      wphase <= next_wphase;
      rdata <= next_rdata;
    end
  end

  // Register writes commit at the end of the data phase; size is not checked.
  always_comb begin
    next_cfg = cfg;
    next_ths = ths;
    next_debounce_count_value = debounce_count_value;
    if (wphase.pending) begin
      unique case (wphase.idx)
        `TD_IDX_CONFIG: begin
          next_cfg = transient_pkg::config_type'(HWDATA[7:0]);
          next_cfg.unused = 3'h0;
        end
        `TD_IDX_THRESH: next_ths = transient_pkg::thresh_type'(HWDATA[7:0]);
        `TD_IDX_COUNT: next_debounce_count_value = HWDATA[7:0];
        default: next_cfg = cfg;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cfg <= transient_pkg::config_type'(`TD_RST_CONFIG);
      ths <= transient_pkg::thresh_type'(`TD_RST_THRESH);
      debounce_count_value <= `TD_RST_COUNT;
    end else begin
      cfg <= next_cfg;
      ths <= next_ths;
      debounce_count_value <= next_debounce_count_value;
    end
  end

  for (genvar a = 0; a < 3; a++) begin : g_axis
    hp_filter u_filter (
      .clk(CLK),
      .reset(RESET),
      .bypass(cfg.hpf_bypass),
      .in_valid(SAMPLE_VALID),
      .in_data(SAMPLE_DATA[a]),
      .out_valid(fvalid[a]),
      .out_data(fdata[a])
    );
    axis_compare u_compare (
      .data(fdata[a]),
      .threshold(ths.ac_threshold_value),
      .above(above[a]),
      .negative(negative[a])
    );
  end

  // Debounce counter and event decision, one step per filtered sample.
  always_comb begin
    tick = &fvalid;
    cond = |(above & cfg.axis_en);
    next_dbc = dbc;
    fire = 1'b0;
    if (tick) begin
      if (cond) begin
        if (dbc < debounce_count_value) begin
          next_dbc = dbc + 8'h01;
        end
        fire = next_dbc >= debounce_count_value;
      end else if (ths.debounce_counter_mode) begin
        next_dbc = 8'h00;
      end else if (dbc != 8'h00) begin
        next_dbc = dbc - 8'h01;
      end
    end
  end

  // Source register update.
  always_comb begin
    live = '0;
    for (int a = 0; a < 3; a++) begin
      live.axis[a].flag = fire && above[a] && cfg.axis_en[a];
      live.axis[a].pol = live.axis[a].flag && negative[a];
    end
    live.any_event_active = live.axis[0].flag || live.axis[1].flag || live.axis[2].flag;
    next_src = src;
    if (!cfg.latch_en) begin
      if (tick) begin
        next_src = live;
      end
    end else begin
      if (rd_clear) begin
        next_src = '0;
      end
      // A new event in the cycle of the clearing read wins over the clear.
      if (fire && (!src.any_event_active || rd_clear)) begin
        next_src = live;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      dbc <= 8'h00;
      src <= transient_pkg::source_type'(`TD_RST_SOURCE);
    end else begin
      dbc <= next_dbc;
      src <= next_src;
    end
  end

  a_reset_values: assert property (@(posedge CLK)
    RESET |=> 8'(cfg) == `TD_RST_CONFIG && 8'(src) == `TD_RST_SOURCE)
    else $error("configuration or source not zero after reset");

  a_source_layout: assert property (@(posedge CLK) disable iff (RESET)
    rd_clear |=> rdata == {24'h000000, $past(8'(src))})
    else $error("source read did not return the source flags");

  a_active_is_or: assert property (@(posedge CLK) disable iff (RESET)
    src.any_event_active == (src.axis[0].flag || src.axis[1].flag || src.axis[2].flag))
    else $error("active bit differs from OR of axis flags");

  a_pol_needs_flag: assert property (@(posedge CLK) disable iff (RESET)
    tick && cfg.latch_en == 1'b0 |=> (src.axis[0].pol -> src.axis[0].flag)
    && (src.axis[0].pol == ($past(negative[0]) && src.axis[0].flag)))
    else $error("X polarity does not match direction of the event");

  a_disabled_axis: assert property (@(posedge CLK) disable iff (RESET)
    fire |-> |(above & cfg.axis_en))
    else $error("event raised with no enabled axis above threshold");

  a_fire_at_count: assert property (@(posedge CLK) disable iff (RESET)
    tick && cond && dbc + 9'h001 >= 9'(debounce_count_value) |-> fire)
    else $error("event not raised when debounce count reached");

  a_count_step: assert property (@(posedge CLK) disable iff (RESET)
    !tick |=> dbc == $past(dbc))
    else $error("debounce counter moved without a sample");

  a_counter_clear: assert property (@(posedge CLK) disable iff (RESET)
    tick && !cond && ths.debounce_counter_mode |=> dbc == 8'h00)
    else $error("debounce counter not cleared in clear mode");

  a_counter_dec: assert property (@(posedge CLK) disable iff (RESET)
    tick && !cond && !ths.debounce_counter_mode && dbc != 8'h00
    |=> dbc == $past(dbc) - 8'h01)
    else $error("debounce counter not decremented in decrement mode");

  a_count_limit: assert property (@(posedge CLK) disable iff (RESET)
    tick && cond && dbc < debounce_count_value |=> dbc == $past(dbc) + 8'h01)
    else $error("debounce counter did not advance on qualifying sample");

  a_latch_hold: assert property (@(posedge CLK) disable iff (RESET)
    cfg.latch_en && src.any_event_active && !rd_clear && !wphase.pending
    |=> src == $past(src))
    else $error("latched source changed without a read");

  a_read_clear: assert property (@(posedge CLK) disable iff (RESET)
    cfg.latch_en && rd_clear && !fire && !wphase.pending |=> !src.any_event_active)
    else $error("latched flag not cleared by source read");

  a_live_follow: assert property (@(posedge CLK) disable iff (RESET)
    !cfg.latch_en && tick && !fire && !wphase.pending |=> !src.any_event_active)
    else $error("real-time flag stayed set without a live event");

  a_bypass_path: assert property (@(posedge CLK) disable iff (RESET)
    SAMPLE_VALID && cfg.hpf_bypass |=> fdata[1] == 16'($signed($past(SAMPLE_DATA[1]))))
    else $error("bypass did not pass the raw Y sample");

  a_thresh_scale: assert property (@(posedge CLK) disable iff (RESET)
    above[2] |-> (negative[2] ? 16'(-fdata[2]) : fdata[2])
    > {3'h0, ths.ac_threshold_value, 6'h00})
    else $error("Z axis above flag disagrees with scaled threshold");

endmodule : transient_detect

// >>> sim/host_bus_master.sv
// Behavioural AHB-Lite host that issues single word transfers to the detector.
module host_bus_master (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Each register sits in its own word, so the byte address is four times the index.
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    // The address is scrambled once taken, so a slave that samples it late is caught.
    haddr <= ~haddr;
    hwdata <= wr ? {24'h0, wd} : ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata[7:0];
  endtask : xfer
endmodule : host_bus_master

// >>> sim/transient_detect_tb.sv
// Self-checking testbench of the transient detector.
`include "transient_map.svh"

module transient_detect_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic reset;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic sample_valid;
  transient_pkg::axes_type sample_data;
  logic event_active;
  logic [7:0] rd;
  logic signed [13:0] v [3];
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  transient_detect i_transient_detect (
    .CLK(clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata),
    .SAMPLE_VALID(sample_valid), .SAMPLE_DATA(sample_data), .EVENT_ACTIVE(event_active)
  );

  host_bus_master i_host_bus_master (
    .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    i_host_bus_master.xfer(1'b1, idx, d, rd);
  endtask : wr

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    i_host_bus_master.xfer(1'b0, idx, 8'h00, rd);
    check(rd, exp);
    check({7'h0, hresp}, 8'h00);
  endtask : rdchk

  // Called on a clock edge; the flag was launched an edge earlier, so it is settled here.
  task automatic evchk(input logic exp);
    check({7'h0, event_active}, {7'h0, exp});
  endtask : evchk

  // The sample bus carries garbage between strobes, so a stale read is not hidden.
  task automatic put(input logic signed [13:0] x, input logic signed [13:0] y,
                     input logic signed [13:0] z);
    sample_data <= {z, y, x};
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    sample_data <= ~sample_data;
    @(posedge clk);
    @(posedge clk);
  endtask : put

  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    reset = 1'b1;
    sample_valid = 1'b0;
    sample_data = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdchk(`TD_IDX_CONFIG, 8'h00);
    rdchk(`TD_IDX_SOURCE, 8'h00);
    rdchk(`TD_IDX_THRESH, 8'h00);
    rdchk(`TD_IDX_COUNT, 8'h00);
    rdchk(8'h10, 8'h00);
    wr(`TD_IDX_CONFIG, 8'hFF);
    rdchk(`TD_IDX_CONFIG, 8'h1F);
    wr(`TD_IDX_SOURCE, 8'hFF);
    rdchk(`TD_IDX_SOURCE, 8'h00);
    wr(`TD_IDX_COUNT, 8'hFF);
    rdchk(`TD_IDX_COUNT, 8'hFF);
    // Bypassed filter, X only, threshold 2 steps (128 counts), three qualifying samples.
    wr(`TD_IDX_CONFIG, 8'h03);
    wr(`TD_IDX_THRESH, 8'h02);
    rdchk(`TD_IDX_THRESH, 8'h02);
    wr(`TD_IDX_COUNT, 8'h03);
    for (int k = 0; k < 3; k++) begin
      put(14'sd200, 14'sd0, 14'sd0);
      evchk(k == 2);
    end
    rdchk(`TD_IDX_SOURCE, 8'h42);
    rdchk(`TD_IDX_DEBUG, 8'h03);
    put(14'sd0, 14'sd0, 14'sd0);
    rdchk(`TD_IDX_DEBUG, 8'h02);
    rdchk(`TD_IDX_SOURCE, 8'h00);
    wr(`TD_IDX_THRESH, 8'h82);
    put(14'sd200, 14'sd0, 14'sd0);
    evchk(1'b1);
    put(14'sd0, 14'sd0, 14'sd0);
    rdchk(`TD_IDX_DEBUG, 8'h00);
    // Each axis alone, first disabled, then enabled; odd axes go negative.
    wr(`TD_IDX_COUNT, 8'h00);
    for (int i = 0; i < 3; i++) begin
      v = '{14'sd0, 14'sd0, 14'sd0};
      v[i] = (i % 2) ? -14'sd300 : 14'sd300;
      wr(`TD_IDX_CONFIG, 8'h0F & ~(8'h02 << i));
      put(v[0], v[1], v[2]);
      rdchk(`TD_IDX_SOURCE, 8'h00);
      wr(`TD_IDX_CONFIG, 8'h01 | (8'h02 << i));
      put(v[0], v[1], v[2]);
      rdchk(`TD_IDX_SOURCE, 8'h40 | (8'h02 << (2 * i)) | ((i % 2) << (2 * i)));
    end
    // Latched: the flag survives a quiet sample and only a source read clears it.
    // A quiet real-time sample first, since switching the latch on keeps the old status.
    put(14'sd0, 14'sd0, 14'sd0);
    evchk(1'b0);
    wr(`TD_IDX_CONFIG, 8'h13);
    put(14'sd200, 14'sd0, 14'sd0);
    put(14'sd0, 14'sd0, 14'sd0);
    evchk(1'b1);
    rdchk(`TD_IDX_SOURCE, 8'h42);
    evchk(1'b0);
    rdchk(`TD_IDX_SOURCE, 8'h00);
    // Filter on: a step trips the detector, a steady level decays below threshold.
    wr(`TD_IDX_CONFIG, 8'h02);
    put(14'sd200, 14'sd0, 14'sd0);
    evchk(1'b1);
    repeat (60) put(14'sd200, 14'sd0, 14'sd0);
    rdchk(`TD_IDX_SOURCE, 8'h00);
    tally_and_finish();
  end
endmodule : transient_detect_tb
